/* core/stf_frame_handler.sv */
// Transmit frame parser, socket table, status framer and register slave
`timescale 1ns/10ps
module stf_frame_handler
  import stf_pkg::*;
#(
  parameter int N_SOCK    = 10,
  parameter int TICK_CYC  = TICK_CYCLES
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  output logic             host_tx_valid_o,
  output logic [7:0]       host_tx_data_o,
  input  wire logic        host_tx_ready_i,
  output logic             pay_valid_o,
  output logic [7:0]       pay_data_o,
  output logic             net_req_o,
  output logic             net_req_sms_o,
  output logic             net_req_new_o,
  output logic [3:0]       net_req_sock_o,
  input  wire logic        net_done_i,
  input  wire logic [7:0]  net_code_i,
  output logic             net_close_o,
  output logic [3:0]       net_close_sock_o,
  input  wire logic        net_rx_valid_i,
  input  wire logic [3:0]  net_rx_sock_i,
  input  wire logic [7:0]  net_rx_data_i,
  output logic             host_rx_valid_o,
  output logic [3:0]       host_rx_sock_o,
  output logic [7:0]       host_rx_data_o,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ***************************************************************
  // Register slave
  // ***************************************************************
  logic [1:0]  ctrl;
  logic [15:0] idle_lim;
  logic [7:0]  last_code;
  logic [7:0]  bad_cnt;
  logic [N_SOCK-1:0] sk_open;
  logic [3:0]  aw_addr;
  logic        aw_full;
  logic        w_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         esc_mode = ctrl[0];
  wire         wr_go = aw_full && w_full && !s_axi_bvalid;
  wire         rd_go = s_axi_arvalid && s_axi_arready;
  wire         wr_map = aw_addr == REG_CTRL || aw_addr == REG_IDLE;
  wire         rd_map = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_IDLE
                     || s_axi_araddr == REG_SOCK || s_axi_araddr == REG_STAT;
  wire  [31:0] rd_val =
    s_axi_araddr == REG_CTRL ? {30'h0, ctrl} :
    s_axi_araddr == REG_IDLE ? {16'h0, idle_lim} :
    s_axi_araddr == REG_SOCK ? 32'(sk_open) :
    s_axi_araddr == REG_STAT ? {16'h0, bad_cnt, last_code} : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      idle_lim <= IDLE_RESET;
    end else begin
      s_axi_awready <= !aw_full && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == REG_CTRL && w_strb[0])
          ctrl <= w_data[1:0];
        if (aw_addr == REG_IDLE && w_strb[0])
          idle_lim[7:0] <= w_data[7:0];
        if (aw_addr == REG_IDLE && w_strb[1])
          idle_lim[15:8] <= w_data[15:8];
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_map ? rd_val : 32'h0;
        s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Frame parser
  // ***************************************************************
  stf_state_e  state;
  logic [15:0] len;
  logic [10:0] idx;
  logic [7:0]  sum;
  logic        esc_pend;
  logic [7:0]  f_type;
  logic [7:0]  f_id;
  logic [31:0] f_addr;
  logic [15:0] f_dport;
  logic [15:0] f_sport;
  logic [7:0]  f_proto;
  logic [7:0]  f_opt;
  logic        ph_bad;
  logic        ph_end;
  logic        chk_ok;
  logic        ser_busy;
  logic        ser_go;
  logic [7:0]  ser_code;
  logic [7:0]  ser_id;
  logic [3:0]  cur_sock;
  logic        cur_close;
  wire         take = rx_valid_i && rx_ready_o;
  wire         restart = take && esc_mode && rx_data_i == START_BYTE;
  wire         esc_mark = take && esc_mode && rx_data_i == ESC_BYTE
                       && !esc_pend;
  wire  [7:0]  din = esc_pend ? (rx_data_i ^ ESC_XOR) : rx_data_i;
  wire         dtake = take && !restart && !esc_mark;
  wire         last_data = {5'h0, idx} + 16'h1 == len;
  wire         is_digit = din >= 8'h30 && din <= 8'h39;
  wire         is_plus = din == 8'h2b;
  wire  [10:0] body_hdr = f_type == TYPE_SMS ? SMS_HDR : IP_HDR;
  wire  [15:0] sms_top = {5'h0, SMS_HDR + SMS_MAX};
  wire  [15:0] ip_top = {5'h0, IP_HDR + IP_MAX};
  wire         proto_ok = f_proto == PROTO_UDP || f_proto == PROTO_TCP
                       || f_proto == PROTO_TLS;

  // Socket lookup against the captured request
  logic        hit;
  logic [3:0]  hit_idx;
  logic        free;
  logic [3:0]  free_idx;
  logic [31:0] sk_addr  [N_SOCK];
  logic [15:0] sk_dport [N_SOCK];
  logic [15:0] sk_sport [N_SOCK];
  logic        sk_udp   [N_SOCK];
  logic [15:0] sk_idle  [N_SOCK];
  always_comb begin
    hit = 1'b0;
    hit_idx = 4'h0;
    free = 1'b0;
    free_idx = 4'h0;
    for (int i = N_SOCK - 1; i >= 0; i--) begin
      if (sk_open[i] && sk_addr[i] == f_addr && sk_dport[i] == f_dport
          && (f_sport == 16'h0 || sk_sport[i] == f_sport)) begin
        hit = 1'b1;
        hit_idx = 4'(i);
      end
      if (!sk_open[i]) begin
        free = 1'b1;
        free_idx = 4'(i);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= S_IDLE;
      len <= 16'h0;
      idx <= 11'h0;
      sum <= 8'h0;
      esc_pend <= 1'b0;
      {f_type, f_id, f_proto, f_opt} <= 32'h0;
      {f_addr, f_dport, f_sport} <= 64'h0;
      {ph_bad, ph_end, chk_ok} <= 3'b000;
      rx_ready_o <= 1'b0;
      pay_valid_o <= 1'b0;
      pay_data_o <= 8'h0;
      net_req_o <= 1'b0;
      net_req_sms_o <= 1'b0;
      net_req_new_o <= 1'b0;
      net_req_sock_o <= 4'h0;
      ser_go <= 1'b0;
      ser_code <= 8'h0;
      ser_id <= 8'h0;
      cur_sock <= 4'h0;
      cur_close <= 1'b0;
      bad_cnt <= 8'h0;
    end else begin
      net_req_o <= 1'b0;
      pay_valid_o <= 1'b0;
      ser_go <= 1'b0;
      rx_ready_o <= (take && state == S_CHK) ? 1'b0 :
        (state inside {S_IDLE, S_LEN_H, S_LEN_L, S_DATA, S_CHK}
         && !ser_busy && !ser_go);
      if (take)
        esc_pend <= esc_mark;
      if (restart) begin
        state <= S_LEN_H;
      end else if (dtake) begin
        case (state)
          S_IDLE: begin
            if (din == START_BYTE)
              state <= S_LEN_H;
          end
          S_LEN_H: begin
            len[15:8] <= din;
            state <= S_LEN_L;
          end
          S_LEN_L: begin
            len[7:0] <= din;
            idx <= 11'h0;
            sum <= 8'h0;
            {ph_bad, ph_end} <= 2'b00;
            state <= {len[15:8], din} == 16'h0 ? S_CHK : S_DATA;
          end
          S_DATA: begin
            sum <= sum + din;
            idx <= idx + 11'h1;
            if (last_data)
              state <= S_CHK;
            if (idx == 11'd0) f_type <= din;
            if (idx == 11'd1) f_id <= din;
            if (f_type == TYPE_IPV4) begin
              if (idx >= 11'd2 && idx <= 11'd5)
                f_addr <= {f_addr[23:0], din};
              if (idx == 11'd6 || idx == 11'd7)
                f_dport <= {f_dport[7:0], din};
              if (idx == 11'd8 || idx == 11'd9)
                f_sport <= {f_sport[7:0], din};
              if (idx == 11'd10) f_proto <= din;
              if (idx == 11'd11) f_opt <= din;
            end
            // Options byte at index 2 is not captured
            if (f_type == TYPE_SMS && idx > 11'd2 && idx <= PHONE_LAST
                && !ph_end) begin
              if (din == 8'h0)
                ph_end <= 1'b1;
              else if (!(is_digit || (is_plus && idx == 11'd3)))
                ph_bad <= 1'b1;
            end
            if (f_type == TYPE_SMS && idx == PHONE_LAST && din != 8'h0
                && !ph_end)
              ph_bad <= 1'b1;
            if (idx >= body_hdr && (f_type == TYPE_SMS
                || f_type == TYPE_IPV4)) begin
              pay_valid_o <= 1'b1;
              pay_data_o <= din;
            end
          end
          S_CHK: begin
            chk_ok <= sum + din == CHK_GOOD;
            state <= S_DEC;
          end
          default: state <= S_IDLE;
        endcase
      end else if (state == S_DEC) begin
        state <= S_IDLE;
        ser_id <= f_id;
        cur_close <= f_type == TYPE_IPV4 && f_proto != PROTO_UDP
                     && f_opt[OPT_CLOSE_BIT];
        if (!chk_ok) begin
          bad_cnt <= bad_cnt + 8'h1;
        end else if (f_type == TYPE_SMS) begin
          if (len > sms_top || ph_bad) begin
            ser_code <= ph_bad ? ST_BAD_FRAME : ST_MSG_LONG;
            ser_go <= f_id != 8'h0;
          end else begin
            net_req_o <= 1'b1;
            net_req_sms_o <= 1'b1;
            net_req_new_o <= 1'b0;
            state <= S_WAIT;
          end
        end else if (f_type == TYPE_IPV4) begin
          net_req_sms_o <= 1'b0;
          if (!proto_ok || len < {5'h0, IP_HDR}) begin
            ser_code <= ST_BAD_MODE;
            ser_go <= f_id != 8'h0;
          end else if (len > ip_top) begin
            ser_code <= ST_MSG_LONG;
            ser_go <= f_id != 8'h0;
          end else if (hit) begin
            net_req_o <= 1'b1;
            net_req_new_o <= 1'b0;
            net_req_sock_o <= hit_idx;
            cur_sock <= hit_idx;
            state <= S_WAIT;
          end else if (f_sport != 16'h0) begin
            ser_code <= f_proto == PROTO_UDP ? ST_BAD_UDP : ST_BAD_TCP;
            ser_go <= f_id != 8'h0;
          end else if (free) begin
            net_req_o <= 1'b1;
            net_req_new_o <= 1'b1;
            net_req_sock_o <= free_idx;
            cur_sock <= free_idx;
            state <= S_WAIT;
          end else begin
            ser_code <= ST_RESOURCE;
            ser_go <= f_id != 8'h0;
          end
        end
      end else if (state == S_WAIT && net_done_i) begin
        state <= S_IDLE;
        ser_code <= net_code_i;
        ser_go <= ser_id != 8'h0;
      end
    end
  end

  // ***************************************************************
  // Socket table and idle timeout
  // ***************************************************************
  logic [$clog2(TICK_CYC)-1:0] tick_cnt;
  wire  tick = tick_cnt == ($clog2(TICK_CYC))'(TICK_CYC - 1);
  wire  new_open = state == S_DEC && chk_ok
                 && f_type == TYPE_IPV4 && proto_ok && !hit && free
                 && f_sport == 16'h0 && len >= {5'h0, IP_HDR}
                 && len <= ip_top;
  wire  done_close = state == S_WAIT && net_done_i && !net_req_sms_o
                   && cur_close;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tick_cnt <= '0;
      sk_open <= '0;
      net_close_o <= 1'b0;
      net_close_sock_o <= 4'h0;
      host_rx_valid_o <= 1'b0;
      host_rx_sock_o <= 4'h0;
      host_rx_data_o <= 8'h0;
      last_code <= 8'h0;
      for (int i = 0; i < N_SOCK; i++) begin
        sk_addr[i] <= 32'h0;
        sk_dport[i] <= 16'h0;
        sk_sport[i] <= 16'h0;
        sk_udp[i] <= 1'b0;
        sk_idle[i] <= 16'h0;
      end
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      net_close_o <= 1'b0;
      if (state == S_WAIT && net_done_i)
        last_code <= net_code_i;
      // Forward network data only for sockets that are open
      host_rx_valid_o <= net_rx_valid_i && 32'(net_rx_sock_i) < N_SOCK
                         && sk_open[net_rx_sock_i];
      host_rx_sock_o <= net_rx_sock_i;
      host_rx_data_o <= net_rx_data_i;
      for (int i = 0; i < N_SOCK; i++) begin
        if (tick && sk_open[i])
          sk_idle[i] <= sk_idle[i] + 16'h1;
        if (sk_open[i] && idle_lim != 16'h0 && sk_idle[i] >= idle_lim
            && !(state == S_WAIT && cur_sock == 4'(i))) begin
          sk_open[i] <= 1'b0;
          net_close_o <= 1'b1;
          net_close_sock_o <= 4'(i);
        end
      end
      if (new_open) begin
        sk_open[free_idx] <= 1'b1;
        sk_addr[free_idx] <= f_addr;
        sk_dport[free_idx] <= f_dport;
        sk_sport[free_idx] <= 16'h0;
        sk_udp[free_idx] <= f_proto == PROTO_UDP;
        sk_idle[free_idx] <= 16'h0;
      end
      if (state == S_WAIT && net_done_i && !net_req_sms_o)
        sk_idle[cur_sock] <= 16'h0;
      if (done_close && !sk_udp[cur_sock]) begin
        sk_open[cur_sock] <= 1'b0;
        net_close_o <= 1'b1;
        net_close_sock_o <= cur_sock;
      end
    end
  end

  // ***************************************************************
  // Status frame serializer
  // ***************************************************************
  logic [2:0] ser_idx;
  logic       ser_esc;
  wire  [7:0] ser_raw =
    ser_idx == 3'd0 ? START_BYTE : ser_idx == 3'd1 ? STATUS_LEN[15:8] :
    ser_idx == 3'd2 ? STATUS_LEN[7:0] : ser_idx == 3'd3 ? TYPE_STATUS :
    ser_idx == 3'd4 ? ser_id : ser_idx == 3'd5 ? ser_code :
    CHK_GOOD - (TYPE_STATUS + ser_id + ser_code);
  wire        ser_need = esc_mode && ser_idx != 3'd0 && (ser_raw == START_BYTE
    || ser_raw == ESC_BYTE || ser_raw == XON_BYTE || ser_raw == XOFF_BYTE);
  wire        out_step = !host_tx_valid_o || host_tx_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ser_busy <= 1'b0;
      ser_idx <= 3'd0;
      ser_esc <= 1'b0;
      host_tx_valid_o <= 1'b0;
      host_tx_data_o <= 8'h0;
    end else if (ser_go) begin
      ser_busy <= 1'b1;
      ser_idx <= 3'd0;
      ser_esc <= 1'b0;
    end else if (out_step) begin
      host_tx_valid_o <= ser_busy;
      if (ser_busy && ser_need && !ser_esc) begin
        host_tx_data_o <= ESC_BYTE;
        ser_esc <= 1'b1;
      end else if (ser_busy) begin
        host_tx_data_o <= ser_esc ? ser_raw ^ ESC_XOR : ser_raw;
        ser_esc <= 1'b0;
        ser_idx <= ser_idx + 3'd1;
        if (ser_idx == STATUS_BYTES - 3'd1)
          ser_busy <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  ready_drop_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    take && state == S_CHK |=> !rx_ready_o)
    else $error("ready stayed high after checksum byte");
  bad_chk_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == S_DEC && !chk_ok |=> !net_req_o && !ser_go)
    else $error("bad checksum frame was acted on");
  zero_id_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ser_go |-> ser_id != 8'h0)
    else $error("status started for zero identifier");
  sport_err_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == S_DEC && chk_ok && f_type == TYPE_IPV4 && f_sport != 16'h0
    && !hit |=> !net_req_o)
    else $error("nonzero source port opened a socket");
  new_sock_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    net_req_o && net_req_new_o |-> f_sport == 16'h0 && !net_req_sms_o
    && sk_open[net_req_sock_o])
    else $error("new socket request without open slot");
  status_head_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ser_go |=> ##1 host_tx_valid_o && host_tx_data_o == START_BYTE)
    else $error("status frame did not start with start byte");
  udp_keep_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == S_WAIT && net_done_i && sk_udp[cur_sock] && !net_req_sms_o
    && sk_open[cur_sock] && idle_lim == 16'h0 |=> sk_open[cur_sock])
    else $error("udp socket closed by option bit");
  req_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    net_req_o |=> !net_req_o [*2])
    else $error("network request longer than one cycle");
endmodule

/* core/stf_pkg.sv */
// Constants for the outbound SMS and IPv4 transmit frame handler
// Functional notes
// - Frame type 0x1F requests sending a short text message.
// - Destination numbers are accepted with or without a leading plus.
// - Second data byte is an echoed identifier; zero suppresses status.
// - Text message options byte is reserved and ignored.
// - Text message body is at most 160 characters.
// - Frame type 0x20 requests an IPv4 payload transmit.
// - A request to a destination without socket creates a new socket; the handler does so only for source port zero.
// - Network data on an open socket is forwarded to the host.
// - Source port zero sends on an open socket matching destination.
// - Source port zero without a match opens a new socket.
// - Nonzero source port sends only on a fully matching socket.
// - Nonzero source port without full match reports an error.
// - TCP with option bit 1 set closes the socket after sending.
// - Option bit 1 clear keeps the socket until idle timeout.
// - UDP requests ignore the socket-termination option bit.
// - IPv4 payload is at most 1500 bytes.
// - Frame starts 0x7E, then two-byte big-endian data length.
// - Checksum is 0xFF minus data byte sum; bad frames ignored.
// - Escaped mode sends reserved bytes as 0x7D then byte xor 0x20.
// - Nonzero identifier gets a 0x89 status frame with id and code.
package stf_pkg;
  localparam logic [7:0] START_BYTE  = 8'h7e;
  localparam logic [7:0] ESC_BYTE    = 8'h7d;
  localparam logic [7:0] ESC_XOR     = 8'h20;
  localparam logic [7:0] XON_BYTE    = 8'h11;
  localparam logic [7:0] XOFF_BYTE   = 8'h13;
  localparam logic [7:0] CHK_GOOD    = 8'hff;
  localparam logic [7:0] TYPE_SMS    = 8'h1f;
  localparam logic [7:0] TYPE_IPV4   = 8'h20;
  localparam logic [7:0] TYPE_STATUS = 8'h89;
  localparam logic [7:0] PROTO_UDP   = 8'h00;
  localparam logic [7:0] PROTO_TCP   = 8'h01;
  localparam logic [7:0] PROTO_TLS   = 8'h04;
  localparam int         OPT_CLOSE_BIT = 1;
  localparam logic [7:0] ST_MSG_LONG = 8'h74;
  localparam logic [7:0] ST_BAD_FRAME = 8'h2c;
  localparam logic [7:0] ST_RESOURCE = 8'h32;
  localparam logic [7:0] ST_BAD_UDP  = 8'h78;
  localparam logic [7:0] ST_BAD_TCP  = 8'h79;
  localparam logic [7:0] ST_BAD_MODE = 8'h7b;
  localparam logic [10:0] SMS_HDR    = 11'd23;
  localparam logic [10:0] SMS_MAX    = 11'd160;
  localparam logic [10:0] IP_HDR     = 11'd12;
  localparam logic [10:0] IP_MAX     = 11'd1500;
  localparam logic [10:0] PHONE_LAST = 11'd22;
  localparam logic [15:0] STATUS_LEN = 16'h0003;
  localparam logic [2:0]  STATUS_BYTES = 3'd7;
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_IDLE    = 4'h4;
  localparam logic [3:0] REG_SOCK    = 4'h8;
  localparam logic [3:0] REG_STAT    = 4'hc;
  localparam logic [1:0] CTRL_RESET  = 2'b00;
  localparam logic [15:0] IDLE_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLK_NS  = 50;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  typedef enum {S_IDLE, S_LEN_H, S_LEN_L, S_DATA, S_CHK, S_DEC, S_WAIT}
    stf_state_e;
endpackage

/* verification/stf_net_model.sv */
// Network side stand-in that finishes each send after a delay
`timescale 1ns/10ps
module stf_net_model
  import stf_pkg::*;
#(
  parameter int DELAY = 5
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       net_req_i,
  output logic            net_done_o,
  output logic [7:0]      net_code_o
);
  int cnt;
  assign net_code_o = 8'h00;
  // One send outstanding; done is a one-cycle pulse
  always_ff @(posedge core_clk_i) begin
    net_done_o <= 1'b0;
    if (reset_i) begin
      cnt <= 0;
    end else if (net_req_i) begin
      cnt <= DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      net_done_o <= (cnt == 1);
    end
  end
endmodule

/* verification/test_sms_ipv4_transmit_frame_handler.sv */
// Self-checking bench for the transmit frame handler
`timescale 1ns/10ps
module test_sms_ipv4_transmit_frame_handler;
  import stf_pkg::*;
  logic core_clk_i, reset_i, rx_valid_i, rx_ready_o, host_tx_valid_o;
  logic [7:0] rx_data_i, host_tx_data_o, pay_data_o, net_code_i;
  logic pay_valid_o, net_req_o, net_req_sms_o, net_req_new_o, net_done_i;
  logic [3:0] net_req_sock_o, aa, ra;
  logic [31:0] wd, rd;
  logic av, ar, wv, wr, bv, br, rv, rr, rq, sq;
  logic [1:0] bp, rp;
  logic [7:0] q[$], d[$], nd, hd;
  logic [3:0] ns, hs;
  logic esc, nv, hv, nc;
  int errors, num_checks, np, ncl;
  stf_frame_handler #(.TICK_CYC(4)) stf_frame_handler_inst (
    .core_clk_i, .reset_i, .rx_valid_i, .rx_data_i, .rx_ready_o,
    .host_tx_valid_o, .host_tx_data_o, .host_tx_ready_i(1'b1), .pay_valid_o,
    .pay_data_o, .net_req_o, .net_req_sms_o, .net_req_new_o, .net_req_sock_o,
    .net_done_i, .net_code_i, .net_close_o(nc), .net_close_sock_o(),
    .net_rx_valid_i(nv), .net_rx_sock_i(ns), .net_rx_data_i(nd),
    .host_rx_valid_o(hv), .host_rx_sock_o(hs), .host_rx_data_o(hd),
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(ar),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(rq), .s_axi_arready(sq),
    .s_axi_rdata(rd), .s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  stf_net_model stf_net_model_inst (.core_clk_i, .reset_i,
    .net_req_i(net_req_o), .net_done_o(net_done_i), .net_code_o(net_code_i));
  always @(posedge core_clk_i) begin
    if (host_tx_valid_o === 1'b1) q.push_back(host_tx_data_o);
    if (pay_valid_o === 1'b1) np++;
    if (nc === 1'b1) ncl++;
  end
  task automatic check(string w, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic put(logic [7:0] b);
    rx_valid_i <= 1'b1;
    rx_data_i <= b;
    @(posedge core_clk_i iff rx_ready_o === 1'b1);
  endtask
  task automatic putx(logic [7:0] b);
    if (esc && b inside {START_BYTE, ESC_BYTE, XON_BYTE, XOFF_BYTE}) begin
      put(ESC_BYTE);
      put(b ^ ESC_XOR);
    end else begin
      put(b);
    end
  endtask
  task automatic frame(logic [7:0] f[$], logic [7:0] adj);
    logic [7:0] s;
    s = 8'h00;
    np = 0;
    foreach (f[i]) s += f[i];
    put(START_BYTE);
    putx(8'h00);
    putx(8'(f.size()));
    foreach (f[i]) putx(f[i]);
    putx(CHK_GOOD - s + adj);
    rx_valid_i <= 1'b0;
  endtask
  task automatic ip(logic [7:0] id, logic [15:0] sp, logic [7:0] pr, adj);
    frame({TYPE_IPV4, id, 8'h0a, 8'h00, 8'h00, 8'h01, 8'h12, 8'h34,
      sp[15:8], sp[7:0], pr,
      8'h02,
      8'ha1, 8'ha2, 8'ha3}, adj);
  endtask
  task automatic status(logic [7:0] id, logic [7:0] c);
    logic [7:0] r[$];
    r = {8'h00, 8'h03, TYPE_STATUS, id, c, CHK_GOOD - TYPE_STATUS - id - c};
    d = {START_BYTE};
    foreach (r[i])
      if (esc && r[i] inside {START_BYTE, ESC_BYTE, XON_BYTE, XOFF_BYTE})
        d = {d, ESC_BYTE, r[i] ^ ESC_XOR};
      else
        d.push_back(r[i]);
    repeat (60) @(posedge core_clk_i);
    check("status size", q.size(), d.size());
    foreach (d[i]) check("status", q.size() > i ? q[i] : 8'hxx, d[i]);
    q = {};
  endtask
  task automatic wreg(logic [3:0] a, logic [31:0] v);
    aa <= a;
    wd <= v;
    av <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    fork
      begin @(posedge core_clk_i iff ar === 1'b1); av <= 1'b0; end
      begin @(posedge core_clk_i iff wr === 1'b1); wv <= 1'b0; end
    join
    @(posedge core_clk_i iff bv === 1'b1);
    br <= 1'b0;
    check("bresp", bp, RESP_OKAY);
  endtask
  task automatic rreg(logic [3:0] a, logic [31:0] e, logic [1:0] r);
    ra <= a;
    rq <= 1'b1;
    rr <= 1'b1;
    @(posedge core_clk_i iff sq === 1'b1);
    rq <= 1'b0;
    @(posedge core_clk_i iff rv === 1'b1);
    rr <= 1'b0;
    check("rdata", rd, e);
    check("rresp", rp, r);
  endtask
  task automatic req(string w, logic e);
    @(posedge core_clk_i iff net_req_o === 1'b1);
    check(w, net_req_new_o, e);
  endtask
  task automatic nrx(logic [3:0] s, logic [7:0] v, logic e);
    nv <= 1'b1;
    ns <= s;
    nd <= v;
    @(posedge core_clk_i);
    nv <= 1'b0;
    @(posedge core_clk_i);
    check("host rx", {hv, hs, hd}, {e, s, v});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    #(50 * 20000);
    errors++;
    results();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {reset_i, rx_valid_i, rx_data_i, aa, ra, wd, av, wv, br, rq, rr} = '1;
    {rx_valid_i, av, wv, br, rq, rr, esc, nv, ns, nd} = '0;
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rreg(REG_CTRL, 32'h0, RESP_OKAY);
    wreg(REG_CTRL, 32'h2);
    rreg(REG_CTRL, 32'h2, RESP_OKAY);
    rreg(4'h6, 32'h0, RESP_SLVERR);
    ip(8'h05, 16'h0, PROTO_UDP, 8'h00);
    req("new", 1'b1);
    status(8'h05, 8'h00);
    check("payload", np, 3);
    rreg(REG_SOCK, 32'h1, RESP_OKAY);
    nrx(4'h0, 8'h5a, 1'b1);
    nrx(4'h3, 8'h5b, 1'b0);
    ip(8'h06, 16'h0, PROTO_UDP, 8'h00);
    req("reuse", 1'b0);
    status(8'h06, 8'h00);
    ip(8'h07, 16'h5555, PROTO_UDP, 8'h00);
    status(8'h07, ST_BAD_UDP);
    ip(8'h08, 16'h0, 8'h02, 8'h00);
    status(8'h08, ST_BAD_MODE);
    ip(8'h09, 16'h0, PROTO_UDP, 8'h01);
    repeat (60) @(posedge core_clk_i);
    check("dropped", q.size(), 0);
    rreg(REG_STAT, 32'h100, RESP_OKAY);
    d = {TYPE_SMS, 8'h00, 8'h00, 8'h2b, 8'h31, 8'h32};
    while (d.size() < 23) d.push_back(8'h00);
    frame({d, 8'h68, 8'h69}, 8'h00);
    repeat (60) @(posedge core_clk_i);
    check("sms", net_req_sms_o, 1'b1);
    check("silent", q.size(), 0);
    check("body", np, 2);
    wreg(REG_CTRL, 32'h1);
    esc = 1'b1;
    ip(8'h11, 16'h0, PROTO_UDP, 8'h00);
    req("escaped", 1'b0);
    status(8'h11, 8'h00);
    wreg(REG_IDLE, 32'h2);
    repeat (20) @(posedge core_clk_i);
    check("closes", ncl, 1);
    rreg(REG_SOCK, 32'h0, RESP_OKAY);
    results();
  end
endmodule
